// ### core/pxo_pkg.sv
// package for the port a / port b alternate override block
// assumes a single clock domain and plain wire-level pin ports
package pxo_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PORT_W = 8;

  // ****************************************
  // port b pin positions
  // ****************************************
  localparam int PB_SS   = 0;
  localparam int PB_SCK  = 1;
  localparam int PB_MOSI = 2;
  localparam int PB_MISO = 3;
  localparam int PB_CMP2A = 4;
  localparam int PB_CMP1A = 5;
  localparam int PB_CMP1B = 6;
  localparam int PB_OC7  = 7;

  // ****************************************
  // reset values of registered pin drive
  // ****************************************
  localparam logic [7:0] RST_PIN_OUT  = 8'h00;
  localparam logic [7:0] RST_PIN_OE_N = 8'hff;
  localparam logic [7:0] RST_PULLUP   = 8'h00;
  localparam logic [7:0] RST_SYNC     = 8'h00;

  // ****************************************
  // overrides that never act on these ports
  // ****************************************
  localparam logic [7:0] NO_TOGGLE    = 8'h00;
  localparam logic [7:0] NO_OVERRIDE  = 8'h00;

  // ****************************************
  // compare modulator modes on port b pin 7
  // ****************************************
  typedef enum logic [0:0]
  {
    OCM_AND = 1'b0,
    OCM_OR  = 1'b1
  } pxo_ocm_t;

endpackage

// ### core/pxo_sync2.sv
// two flip-flop synchroniser for a vector of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module pxo_sync2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ### core/pxo_pin_ctrl.sv
// generic override cell for one port pin
// assumes override signals come from logic on the same clock
`timescale 1ns/1ps
module pxo_pin_ctrl (
  // port register bits
  input  wire logic pin_direction_bit,
  input  wire logic pin_output_bit,
  input  wire logic global_pullup_off,
  // alternate function overrides
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic direction_override_en,
  input  wire logic direction_override_val,
  input  wire logic value_override_en,
  input  wire logic value_override_val,
  input  wire logic toggle_override_en,
  // resulting pin drive
  output logic      pin_val,
  output logic      pin_drive,
  output logic      pin_pullup
);

  wire out_bit;
  wire plain_pullup;

  // toggle inverts the output bit before any value override
  assign out_bit = pin_output_bit ^ toggle_override_en;

  // direction: override wins when enabled
  assign pin_drive = direction_override_en ? direction_override_val : pin_direction_bit;

  // value: override only matters while driver is on
  assign pin_val = (value_override_en && pin_drive) ? value_override_val : out_bit;

  // pull-up only for input with output bit one and global enable
  assign plain_pullup = !pin_direction_bit && pin_output_bit && !global_pullup_off;
  assign pin_pullup   = pullup_override_en ? pullup_override_val : plain_pullup;

endmodule

// ### core/pxo_port_override.sv
// alternate function override logic for port a and port b
// assumes memory, timer and spi engines sit on the same clock
// assumes pad logic resolves pin level from out and oe_n
`timescale 1ns/1ps
//
// Behaviour
// - a set global pull-up disable turns every normal pull-up off.
// - port a pin n carries address bit n then data bit n.
// - memory on with address phase or write forces port a pull-ups off.
// - memory on drives port a only in address phase or write, else input.
// - driven port a value is address during address phase, write data in a write, their or when both are on.
// - each port a pin input feeds the memory read data bit n.
// - port b pins 7 to 4 carry the timer compare outputs.
// - port b pins 3 to 0 serve miso, mosi, sck and slave select.
// - port b pin 7 takes timer0 compare a or timer1 compare c.
// - compare pins also carry the pwm waveforms of their timers.
// - without override a pull-up is on only for input, output bit one, no disable.
// - value override applies while the driver is on, else the output bit.
// - spi master forces miso to input, pull-up still from the output bit.
// - spi slave keeps slave select as input, active low from the far master.
//
module pxo_port_override (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,

  // global port control
  input  wire logic       global_pullup_off,

  // port a register bits
  input  wire logic [7:0] porta_direction_bit,
  input  wire logic [7:0] porta_output_bit,

  // port b register bits
  input  wire logic [7:0] portb_direction_bit,
  input  wire logic [7:0] portb_output_bit,

  // external memory interface
  input  wire logic       ext_mem_enable,
  input  wire logic       address_phase_active,
  input  wire logic       mem_write_strobe,
  input  wire logic [7:0] mem_addr_low,
  input  wire logic [7:0] mem_write_data,
  output logic      [7:0] mem_read_data,

  // timer compare outputs
  input  wire logic       timer0_compare_a_out,
  input  wire logic       timer0_compare_a_en,
  input  wire logic       timer1_compare_a_out,
  input  wire logic       timer1_compare_a_en,
  input  wire logic       timer1_compare_b_out,
  input  wire logic       timer1_compare_b_en,
  input  wire logic       timer1_compare_c_out,
  input  wire logic       timer1_compare_c_en,
  input  wire logic       timer2_compare_a_out,
  input  wire logic       timer2_compare_a_en,
  input  wire logic       ocm_mode_or,

  // spi engine
  input  wire logic       spi_on_bit,
  input  wire logic       spi_master_select_bit,
  input  wire logic       spi_master_data_out,
  input  wire logic       spi_slave_data_out,
  input  wire logic       spi_sck_out,
  output logic            spi_master_data_in,
  output logic            spi_slave_data_in,
  output logic            spi_sck_in,
  output logic            spi_slave_select_n,

  // port a pins
  input  wire logic [7:0] porta_pin_in,
  output logic      [7:0] porta_pin_out,
  output logic      [7:0] porta_pin_oe_n,
  output logic      [7:0] porta_pullup,

  // port b pins
  input  wire logic [7:0] portb_pin_in,
  output logic      [7:0] portb_pin_out,
  output logic      [7:0] portb_pin_oe_n,
  output logic      [7:0] portb_pullup
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] porta_sync;
  logic [7:0] portb_sync;

  wire        mem_bus_out;
  wire        mem_pullup_kill;
  wire [7:0]  porta_pue;
  wire [7:0]  porta_dde;
  wire [7:0]  porta_ddv;
  wire [7:0]  porta_pve;
  wire [7:0]  porta_pvv;

  wire        spi_master;
  wire        spi_slave;
  wire        pin7_both;
  wire        pin7_mod;
  wire        pin7_en;
  wire        pin7_val;
  wire [7:0]  portb_pue;
  wire [7:0]  portb_puv;
  wire [7:0]  portb_dde;
  wire [7:0]  portb_pve;
  wire [7:0]  portb_pvv;
  wire [7:0]  spi_pullup_val;

  wire [7:0]  porta_val;
  wire [7:0]  porta_drive;
  wire [7:0]  porta_pu;
  wire [7:0]  portb_val;
  wire [7:0]  portb_drive;
  wire [7:0]  portb_pu;

  logic [7:0] porta_out_ff;
  logic [7:0] porta_oe_n_ff;
  logic [7:0] porta_pu_ff;
  logic [7:0] portb_out_ff;
  logic [7:0] portb_oe_n_ff;
  logic [7:0] portb_pu_ff;

  // ****************************************
  // pin input synchronisers
  // ****************************************
  // pin levels are asynchronous, so no logic reads them raw
  pxo_sync2 #(
    .W (8)
  ) u_sync_a (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (porta_pin_in),
    .sync_out (porta_sync)
  );

  pxo_sync2 #(
    .W (8)
  ) u_sync_b (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (portb_pin_in),
    .sync_out (portb_sync)
  );

  // ****************************************
  // port a: multiplexed address / data bus
  // ****************************************
  // bus is driven in address phase or during a write
  assign mem_bus_out     = address_phase_active || mem_write_strobe;
  assign mem_pullup_kill = ext_mem_enable && mem_bus_out;

  // per pin overrides, identical for all eight lines
  assign porta_pue = {8{mem_pullup_kill}};
  assign porta_dde = {8{ext_mem_enable}};
  assign porta_ddv = {8{mem_bus_out}};
  assign porta_pve = {8{ext_mem_enable}};

  // address and write data share the pins, each gated by its phase and ored
  assign porta_pvv = (mem_addr_low & {8{address_phase_active}})
                    | (mem_write_data & {8{mem_write_strobe}});

  // read data straight from the synchronised pins
  assign mem_read_data = porta_sync;

  // ****************************************
  // port b: spi mode decode
  // ****************************************
  assign spi_master = spi_on_bit && spi_master_select_bit;
  assign spi_slave  = spi_on_bit && !spi_master_select_bit;

  // forced inputs keep the pull-up of the output bit
  assign spi_pullup_val = portb_output_bit & {8{!global_pullup_off}};

  // ****************************************
  // port b: pin 7 compare modulator
  // ****************************************
  // both sources on would otherwise fight, so they are combined
  assign pin7_both = timer0_compare_a_en && timer1_compare_c_en;
  assign pin7_mod  = (ocm_mode_or == pxo_pkg::OCM_OR)
                   ? (timer0_compare_a_out || timer1_compare_c_out)
                   : (timer0_compare_a_out && timer1_compare_c_out);
  assign pin7_en   = timer0_compare_a_en || timer1_compare_c_en;
  assign pin7_val  = pin7_both ? pin7_mod
                   : (timer0_compare_a_en ? timer0_compare_a_out
                                          : timer1_compare_c_out);

  // ****************************************
  // port b: override vectors
  // ****************************************
  // compare pins: value only, direction stays software's
  // pwm waveforms arrive on the same compare lines
  assign portb_pve[pxo_pkg::PB_OC7]   = pin7_en;
  assign portb_pvv[pxo_pkg::PB_OC7]   = pin7_val;
  assign portb_pve[pxo_pkg::PB_CMP1B] = timer1_compare_b_en;
  assign portb_pvv[pxo_pkg::PB_CMP1B] = timer1_compare_b_out;
  assign portb_pve[pxo_pkg::PB_CMP1A] = timer1_compare_a_en;
  assign portb_pvv[pxo_pkg::PB_CMP1A] = timer1_compare_a_out;
  assign portb_pve[pxo_pkg::PB_CMP2A] = timer2_compare_a_en;
  assign portb_pvv[pxo_pkg::PB_CMP2A] = timer2_compare_a_out;

  // miso: input as master, slave data out as slave
  assign portb_dde[pxo_pkg::PB_MISO] = spi_master;
  assign portb_pve[pxo_pkg::PB_MISO] = spi_slave;
  assign portb_pvv[pxo_pkg::PB_MISO] = spi_slave_data_out;

  // mosi: input as slave, master data out as master
  assign portb_dde[pxo_pkg::PB_MOSI] = spi_slave;
  assign portb_pve[pxo_pkg::PB_MOSI] = spi_master;
  assign portb_pvv[pxo_pkg::PB_MOSI] = spi_master_data_out;

  // sck: input as slave, clock out as master
  assign portb_dde[pxo_pkg::PB_SCK]  = spi_slave;
  assign portb_pve[pxo_pkg::PB_SCK]  = spi_master;
  assign portb_pvv[pxo_pkg::PB_SCK]  = spi_sck_out;

  // slave select: input as slave, never value overridden
  assign portb_dde[pxo_pkg::PB_SS]   = spi_slave;
  assign portb_pve[pxo_pkg::PB_SS]   = 1'b0;
  assign portb_pvv[pxo_pkg::PB_SS]   = 1'b0;

  // compare pins never touch direction or pull-up
  assign portb_dde[7:4] = pxo_pkg::NO_OVERRIDE[7:4];

  // forced-input spi pins take the pull-up override
  assign portb_pue = {4'h0, portb_dde[3:0]};
  assign portb_puv = {4'h0, spi_pullup_val[3:0]};

  // ****************************************
  // spi inputs to the engine
  // ****************************************
  assign spi_master_data_in = portb_sync[pxo_pkg::PB_MISO];
  assign spi_slave_data_in  = portb_sync[pxo_pkg::PB_MOSI] && rstn;
  assign spi_sck_in         = portb_sync[pxo_pkg::PB_SCK];
  // slave select idles high outside slave mode
  assign spi_slave_select_n = spi_slave ? portb_sync[pxo_pkg::PB_SS] : 1'b1;

  // ****************************************
  // per pin override cells
  // ****************************************
  // toggle overrides stay tied off on both ports
  genvar gi;
  generate
    for (gi = 0; gi < pxo_pkg::PORT_W; gi++)
    begin : g_pin
      pxo_pin_ctrl u_pa (
        .pin_direction_bit      (porta_direction_bit[gi]),
        .pin_output_bit         (porta_output_bit[gi]),
        .global_pullup_off      (global_pullup_off),
        .pullup_override_en     (porta_pue[gi]),
        .pullup_override_val    (1'b0),
        .direction_override_en  (porta_dde[gi]),
        .direction_override_val (porta_ddv[gi]),
        .value_override_en      (porta_pve[gi]),
        .value_override_val     (porta_pvv[gi]),
        .toggle_override_en     (pxo_pkg::NO_TOGGLE[gi]),
        .pin_val                (porta_val[gi]),
        .pin_drive              (porta_drive[gi]),
        .pin_pullup             (porta_pu[gi])
      );

      pxo_pin_ctrl u_pb (
        .pin_direction_bit      (portb_direction_bit[gi]),
        .pin_output_bit         (portb_output_bit[gi]),
        .global_pullup_off      (global_pullup_off),
        .pullup_override_en     (portb_pue[gi]),
        .pullup_override_val    (portb_puv[gi]),
        .direction_override_en  (portb_dde[gi]),
        .direction_override_val (1'b0),
        .value_override_en      (portb_pve[gi]),
        .value_override_val     (portb_pvv[gi]),
        .toggle_override_en     (pxo_pkg::NO_TOGGLE[gi]),
        .pin_val                (portb_val[gi]),
        .pin_drive              (portb_drive[gi]),
        .pin_pullup             (portb_pu[gi])
      );
    end
  endgenerate

  // ****************************************
  // registered pin drive
  // ****************************************
  // one flop stage keeps pad outputs glitch free
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      porta_out_ff  <= pxo_pkg::RST_PIN_OUT;
      porta_oe_n_ff <= pxo_pkg::RST_PIN_OE_N;
      porta_pu_ff   <= pxo_pkg::RST_PULLUP;
    end
    else
    begin
      porta_out_ff  <= porta_val;
      porta_oe_n_ff <= ~porta_drive;
      porta_pu_ff   <= porta_pu;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      portb_out_ff  <= pxo_pkg::RST_PIN_OUT;
      portb_oe_n_ff <= pxo_pkg::RST_PIN_OE_N;
      portb_pu_ff   <= pxo_pkg::RST_PULLUP;
    end
    else
    begin
      portb_out_ff  <= portb_val;
      portb_oe_n_ff <= ~portb_drive;
      portb_pu_ff   <= portb_pu;
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  assign porta_pin_out  = porta_out_ff;
  assign porta_pin_oe_n = porta_oe_n_ff;
  assign porta_pullup   = porta_pu_ff;
  assign portb_pin_out  = portb_out_ff;
  assign portb_pin_oe_n = portb_oe_n_ff;
  assign portb_pullup   = portb_pu_ff;

endmodule

// ### tb/pxo_port_override_properties.sv
// checker: pin relations and latencies of the port a / port b override block
// assumes one clock, synchronous active-low reset, pin outputs one cycle behind inputs
`timescale 1ns/1ps
module pxo_port_override_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // controls
  input wire logic       global_pullup_off,
  input wire logic [7:0] porta_direction_bit,
  input wire logic [7:0] porta_output_bit,
  input wire logic [7:0] portb_direction_bit,
  input wire logic [7:0] portb_output_bit,
  input wire logic       ext_mem_enable,
  input wire logic       address_phase_active,
  input wire logic       mem_write_strobe,
  input wire logic [7:0] mem_addr_low,
  input wire logic [7:0] mem_write_data,
  input wire logic       timer0_compare_a_out,
  input wire logic       timer0_compare_a_en,
  input wire logic       timer1_compare_b_out,
  input wire logic       timer1_compare_b_en,
  input wire logic       timer1_compare_c_out,
  input wire logic       timer1_compare_c_en,
  input wire logic       ocm_mode_or,
  input wire logic       spi_on_bit,
  input wire logic       spi_master_select_bit,
  // pins and read paths
  input wire logic [7:0] porta_pin_in,
  input wire logic [7:0] portb_pin_in,
  input wire logic [7:0] mem_read_data,
  input wire logic       spi_slave_select_n,
  input wire logic [7:0] porta_pin_out,
  input wire logic [7:0] porta_pin_oe_n,
  input wire logic [7:0] porta_pullup,
  input wire logic [7:0] portb_pin_out,
  input wire logic [7:0] portb_pin_oe_n,
  input wire logic [7:0] portb_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ****
  // bus phases and spi slave mode
  // ****
  sequence s_mem_busy;
    ext_mem_enable && (address_phase_active || mem_write_strobe);
  endsequence
  sequence s_addr_only;
    ext_mem_enable && address_phase_active && !mem_write_strobe;
  endsequence
  sequence s_write_only;
    ext_mem_enable && mem_write_strobe && !address_phase_active;
  endsequence
  sequence s_slave;
    spi_on_bit && !spi_master_select_bit;
  endsequence

  // ****
  // port a, and global pull-up disable on both ports
  // ****
  property p_pu_off_all;
    global_pullup_off |=> porta_pullup == 8'h00 && portb_pullup == 8'h00;
  endproperty
  a_pu_off_all: assert property (p_pu_off_all)
    else $error("pull-up on while disabled");
  property p_busy_drive;
    s_mem_busy |=> porta_pullup == 8'h00 && porta_pin_oe_n == 8'h00;
  endproperty
  a_busy_drive: assert property (p_busy_drive)
    else $error("busy bus not driven");
  property p_idle_release;
    ext_mem_enable && !address_phase_active && !mem_write_strobe |=> porta_pin_oe_n == 8'hff;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("idle bus not released");
  property p_addr_drive;
    s_addr_only |=> porta_pin_out == $past(mem_addr_low);
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("wrong address on bus");
  property p_wdata_drive;
    s_write_only |=> porta_pin_out == $past(mem_write_data);
  endproperty
  a_wdata_drive: assert property (p_wdata_drive)
    else $error("wrong write data on bus");
  property p_read_path;
    1'b1 |-> ##2 mem_read_data == $past(porta_pin_in, 2);
  endproperty
  a_read_path: assert property (p_read_path)
    else $error("read data lost");
  property p_normal_a;
    !ext_mem_enable |=> porta_pin_oe_n == ~$past(porta_direction_bit)
      && (porta_pin_out & ~porta_pin_oe_n) == ($past(porta_output_bit) & ~porta_pin_oe_n);
  endproperty
  a_normal_a: assert property (p_normal_a)
    else $error("plain port a drive wrong");
  property p_pullup_a;
    !(ext_mem_enable && (address_phase_active || mem_write_strobe)) |=> porta_pullup ==
      (~$past(porta_direction_bit) & $past(porta_output_bit) & {8{!$past(global_pullup_off)}});
  endproperty
  a_pullup_a: assert property (p_pullup_a)
    else $error("port a pull-up wrong");

  // ****
  // port b
  // ****
  property p_cmp_b;
    timer1_compare_b_en && portb_direction_bit[6] |=>
      !portb_pin_oe_n[6] && portb_pin_out[6] == $past(timer1_compare_b_out);
  endproperty
  a_cmp_b: assert property (p_cmp_b)
    else $error("compare value missing");
  property p_cmp_dir;
    !portb_direction_bit[6] |=> portb_pin_oe_n[6];
  endproperty
  a_cmp_dir: assert property (p_cmp_dir)
    else $error("compare forced direction");
  property p_pin7_mod;
    timer0_compare_a_en && timer1_compare_c_en && portb_direction_bit[7] |=> portb_pin_out[7] ==
      ($past(ocm_mode_or) ? ($past(timer0_compare_a_out) | $past(timer1_compare_c_out))
                          : ($past(timer0_compare_a_out) & $past(timer1_compare_c_out)));
  endproperty
  a_pin7_mod: assert property (p_pin7_mod)
    else $error("pin 7 modulator wrong");
  property p_master_miso;
    spi_on_bit && spi_master_select_bit |=> portb_pin_oe_n[3]
      && portb_pullup[3] == ($past(portb_output_bit[3]) && !$past(global_pullup_off));
  endproperty
  a_master_miso: assert property (p_master_miso)
    else $error("master input pin wrong");
  property p_slave_in;
    s_slave |=> portb_pin_oe_n[2:0] == 3'b111;
  endproperty
  a_slave_in: assert property (p_slave_in)
    else $error("slave inputs driven");
  property p_slave_sel;
    rstn [*3] ##0 s_slave |-> spi_slave_select_n == $past(portb_pin_in[0], 2);
  endproperty
  a_slave_sel: assert property (p_slave_sel)
    else $error("slave select not seen");
endmodule

bind pxo_port_override pxo_port_override_chk u_pxo_port_override_chk (.*);

// ### tb/pxo_xmem_model.sv
// behavioural external memory on the multiplexed address/data lines
// assumes the bench hands it the address, write and read strobes
`timescale 1ns/1ps
module pxo_xmem_model (
  // clock
  input wire logic       clk,
  // strobes
  input wire logic       latch_addr,
  input wire logic       write_en,
  input wire logic       read_en,
  // device pin drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // resolved line level
  output logic     [7:0] pad_level
);
  logic [7:0] mem_ff [256];
  logic [7:0] addr_ff = 8'h00;
  logic [7:0] last_ff = 8'h00;
  logic [7:0] drive_val;
  // released lines keep nothing: idle shows the inverse of the last level
  assign drive_val = read_en ? mem_ff[addr_ff] : ~last_ff;
  assign pad_level = (pin_out & ~pin_oe_n) | (drive_val & pin_oe_n);
  // latch address in its phase, store data in a write
  always_ff @(posedge clk)
  begin
    last_ff <= pad_level;
    if (latch_addr && pin_oe_n == 8'h00)
      addr_ff <= pad_level;
    if (write_en && pin_oe_n == 8'h00)
      mem_ff[addr_ff] <= pad_level;
  end
endmodule

// ### tb/port_a_b_alternate_override_tb.sv
// self-checking bench for the port a / port b override block
// assumes the design and memory model files are compiled first
`timescale 1ns/1ps
module port_a_b_alternate_override_tb;
  typedef struct { logic gpo, men, ada, wr; logic [7:0] dir, obit, e_oen, e_out, e_pu; } pxo_row_t;
  // address 5a and write data c3 stay fixed through the table
  pxo_row_t rows [8] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 8'hf0, 8'ha5, 8'h0f, 8'ha5, 8'h05},
    '{1'b1, 1'b0, 1'b0, 1'b0, 8'hf0, 8'ha5, 8'h0f, 8'ha5, 8'h00},
    '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff},
    '{1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 8'hff, 8'h00, 8'h5a, 8'h00},
    '{1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'hff, 8'h00, 8'hc3, 8'h00},
    '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 8'hdb, 8'h00},
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h3c, 8'hff, 8'h00, 8'h3c},
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00}};
  logic       clk = 1'b0, rstn = 1'b0, global_pullup_off = 1'b0, ocm_mode_or = 1'b0;
  logic       ext_mem_enable = 1'b0, address_phase_active = 1'b0, mem_write_strobe = 1'b0;
  logic       mem_read_strobe = 1'b0, spi_on_bit = 1'b0, spi_master_select_bit = 1'b0;
  logic       spi_master_data_out = 1'b1, spi_slave_data_out = 1'b1, spi_sck_out = 1'b0;
  logic       timer0_compare_a_out = 1'b1, timer0_compare_a_en = 1'b0, timer1_compare_a_out = 1'b1;
  logic       timer1_compare_a_en = 1'b0, timer1_compare_b_out = 1'b0, timer1_compare_b_en = 1'b0;
  logic       timer1_compare_c_out = 1'b0, timer1_compare_c_en = 1'b0, timer2_compare_a_out = 1'b1;
  logic       timer2_compare_a_en = 1'b0;
  logic [7:0] porta_direction_bit = 8'h00, porta_output_bit = 8'h00, portb_direction_bit = 8'h00;
  logic [7:0] portb_output_bit = 8'h00, mem_addr_low = 8'h5a, mem_write_data = 8'hc3;
  logic [7:0] portb_pin_in = 8'hff, porta_pin_in, mem_read_data, porta_pin_out, porta_pin_oe_n;
  logic [7:0] porta_pullup, portb_pin_out, portb_pin_oe_n, portb_pullup;
  logic       spi_master_data_in, spi_slave_data_in, spi_sck_in, spi_slave_select_n;
  int         mismatches = 0, compares = 0, cycles = 0;

  // ****
  // design, memory model, clock
  // ****
  pxo_port_override u_pxo_port_override (.*);
  pxo_xmem_model u_pxo_xmem_model (.clk, .latch_addr(address_phase_active), .write_en(mem_write_strobe),
    .read_en(mem_read_strobe), .pin_out(porta_pin_out), .pin_oe_n(porta_pin_oe_n), .pad_level(porta_pin_in));
  always #4 clk = ~clk;

  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus state held for n sampled edges
  task automatic bus(input logic ada, input logic wr, input logic rd, input int n);
    @(posedge clk);
    address_phase_active <= ada;
    mem_write_strobe <= wr;
    mem_read_strobe <= rd;
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, run takes about 80 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {global_pullup_off, ext_mem_enable, address_phase_active, mem_write_strobe} <=
        {rows[i].gpo, rows[i].men, rows[i].ada, rows[i].wr};
      porta_direction_bit <= rows[i].dir;
      porta_output_bit <= rows[i].obit;
      settle();
      chk("porta_oe_n", porta_pin_oe_n, rows[i].e_oen);
      chk("porta_out", porta_pin_out & ~rows[i].e_oen, rows[i].e_out & ~rows[i].e_oen);
      chk("porta_pullup", porta_pullup, rows[i].e_pu);
    end
    $display("table done");
    // write c3 at 5a through the pins, then read it back from the memory
    bus(1'b1, 1'b0, 1'b0, 2);
    bus(1'b0, 1'b1, 1'b0, 2);
    bus(1'b0, 1'b0, 1'b0, 3);
    mem_write_data <= 8'h00;
    bus(1'b1, 1'b0, 1'b0, 2);
    bus(1'b0, 1'b0, 1'b1, 4);
    #1;
    chk("mem_read_data", mem_read_data, 8'hc3);
    $display("memory done");
    @(posedge clk);
    {ext_mem_enable, mem_read_strobe} <= 2'b00;
    portb_direction_bit <= 8'hf0;
    {timer1_compare_a_en, timer1_compare_b_en, timer2_compare_a_en, timer0_compare_a_en} <= 4'hf;
    settle();
    chk("compare_pins", 8'(portb_pin_out[7:4]), 8'h0b);
    // pin 7: each source alone, then both through and / or
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      timer0_compare_a_en <= (m != 1);
      timer1_compare_c_en <= (m != 0);
      ocm_mode_or <= (m == 3);
      settle();
      chk("pin7", 8'(portb_pin_out[7]), 8'((m == 0) || (m == 3)));
    end
    @(posedge clk);
    portb_direction_bit <= 8'h00;
    settle();
    chk("compare_dir", 8'(portb_pin_oe_n[7:4]), 8'h0f);
    $display("compare done");
    @(posedge clk);
    {spi_on_bit, spi_master_select_bit} <= 2'b11;
    portb_direction_bit <= 8'h0f;
    portb_output_bit <= 8'h08;
    settle();
    chk("master_oe_n", 8'(portb_pin_oe_n[3:0]), 8'h08);
    chk("master_pullup", 8'(portb_pullup[3:0]), 8'h08);
    chk("master_out", 8'(portb_pin_out[2:1]), 8'h02);
    @(posedge clk);
    spi_master_select_bit <= 1'b0;
    portb_output_bit <= 8'h05;
    portb_pin_in <= 8'hfe;
    settle();
    chk("slave_oe_n", 8'(portb_pin_oe_n[3:0]), 8'h07);
    chk("slave_pullup", 8'(portb_pullup[3:0]), 8'h05);
    chk("slave_out", 8'(portb_pin_out[3]), 8'h01);
    repeat (2) settle();
    chk("select_low", 8'(spi_slave_select_n), 8'h00);
    chk("spi_ins", {5'h00, spi_master_data_in, spi_slave_data_in, spi_sck_in}, 8'h07);
    @(posedge clk);
    portb_pin_in <= 8'hff;
    repeat (3) settle();
    chk("select_high", 8'(spi_slave_select_n), 8'h01);
    $display("spi done");
    // reset in mid-run with port b driving
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) settle();
    chk("rst_oe_n", portb_pin_oe_n, pxo_pkg::RST_PIN_OE_N);
    chk("rst_out", portb_pin_out, pxo_pkg::RST_PIN_OUT);
    chk("rst_pullup", porta_pullup, pxo_pkg::RST_PULLUP);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    $display("reset done");
    tally_and_finish();
  end
endmodule
